// ### rav_cfg.svh
// register offsets, field positions, reset values and voltage steps of the
// alternate regulator setting bank; definitions only
`ifndef RAV_CFG_SVH
`define RAV_CFG_SVH

// ************************************************************
// register indices (byte address is four times the index)
// ************************************************************
`define RAV_IDX_CORE1      8'hb5
`define RAV_IDX_PROCESSOR  8'hb6
`define RAV_IDX_MEMORY     8'hb7
`define RAV_IDX_IO         8'hb8
`define RAV_IDX_PERIPHERAL 8'hb9
`define RAV_IDX_LINEAR_ONE 8'hba
`define RAV_IDX_SET_CTRL   8'hf0
`define RAV_IDX_SET_STATUS 8'hf1

// ************************************************************
// field positions
// ************************************************************
`define RAV_SLEEP_BIT      7
`define RAV_RESERVED_BIT   6
`define RAV_BUCK_CODE_MSB  6
`define RAV_LDO_CODE_MSB   5
`define RAV_ALT_SELECT_BIT 0

// ************************************************************
// reset values and write masks
// ************************************************************
`define RAV_SETTING_RESET  8'h00
`define RAV_BUCK_WR_MASK   8'hff
`define RAV_LDO_WR_MASK    8'hbf

// ************************************************************
// voltage code scaling in millivolts
// ************************************************************
`define RAV_CORE1_BASE_MV  11'd300
`define RAV_CORE1_STEP_MV  11'd10
`define RAV_FIRST_LINEAR_REGULATOR_BASE_MV   11'd600
`define RAV_FIRST_LINEAR_REGULATOR_STEP_MV   11'd20

`endif

// ### rav_fwd.sv
// forwards stored alternate settings to the regulator controls
// assumes the caller says whether the alternate set is selected
`timescale 1ns/100ps
`include "rav_cfg.svh"
module rav_fwd
  import rav_pkg::*;
(
  input  wire logic             mclk,
  input  wire logic             reset,
  input  wire logic             alt_selected,
  input  wire logic [47:0]      words,
  output rav_buck_ctl_type      core1_ctl,
  output rav_buck_ctl_type      processor_ctl,
  output rav_buck_ctl_type      memory_ctl,
  output rav_buck_ctl_type      io_ctl,
  output rav_buck_ctl_type      peripheral_ctl,
  output rav_ldo_ctl_type       linear_one_ctl,
  output logic                  applied
);

  function automatic rav_buck_ctl_type buck_of(input logic [7:0] w);
    rav_buck_ctl_type c;
    c.sleep = w[`RAV_SLEEP_BIT];
    c.code  = w[`RAV_BUCK_CODE_MSB:0];
    return c;
  endfunction : buck_of

  // ************************************************************
  // registered forwarding, zero while the main set is in use
  // ************************************************************
  always_ff @(posedge mclk)
  begin
    if (reset || !alt_selected)
    begin
      core1_ctl      <= '0;
      processor_ctl  <= '0;
      memory_ctl     <= '0;
      io_ctl         <= '0;
      peripheral_ctl <= '0;
      linear_one_ctl <= '0;
      applied        <= 1'b0;
    end
    else
    begin
      core1_ctl      <= buck_of(words[7:0]);
      processor_ctl  <= buck_of(words[15:8]);
      memory_ctl     <= buck_of(words[23:16]);
      io_ctl         <= buck_of(words[31:24]);
      peripheral_ctl <= buck_of(words[39:32]);
      linear_one_ctl <= {words[40+`RAV_SLEEP_BIT], words[40 +: 6]};
      applied        <= 1'b1;
    end
  end

endmodule : rav_fwd

// ### rav_pkg.sv
// types shared by the alternate regulator setting bank
// assumes rav_cfg.svh for the numeric constants
package rav_pkg;

  // ************************************************************
  // regulator control carriers
  // ************************************************************
  typedef struct packed {
    logic       sleep;
    logic [6:0] code;
  } rav_buck_ctl_type;

  typedef struct packed {
    logic       sleep;
    logic [5:0] code;
  } rav_ldo_ctl_type;

  // ************************************************************
  // bus handling
  // ************************************************************
  typedef enum logic [1:0] {
    RAV_IDLE,
    RAV_FETCH,
    RAV_ANSWER
  } rav_bus_state_type;

  typedef struct packed {
    logic       write;
    logic [7:0] index;
    logic [7:0] data;
    logic [7:0] strobe_mask;
  } rav_bus_req_type;

endpackage : rav_pkg

// ### rav_regmem.sv
// small register memory holding the six alternate setting words
// assumes one write port and one registered read port on mclk
`timescale 1ns/100ps
`include "rav_cfg.svh"
module rav_regmem
#(
  parameter int         DEPTH      = 6,
  parameter int         WIDTH      = 8,
  parameter logic [7:0] RESET_WORD = `RAV_SETTING_RESET
)
(
  input  wire logic                   mclk,
  input  wire logic                   reset,
  input  wire logic                   wr_en,
  input  wire logic [2:0]             wr_slot,
  input  wire logic [WIDTH-1:0]       wr_data,
  input  wire logic [2:0]             rd_slot,
  output logic      [WIDTH-1:0]       rd_data,
  output logic      [DEPTH*WIDTH-1:0] all_words
);

  logic [WIDTH-1:0] store [DEPTH];

  // words stay until rewritten or reset; flat copy feeds the regulator controls
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      for (int i = 0; i < DEPTH; i++)
        store[i] <= WIDTH'(RESET_WORD);
    end
    else if (wr_en && (int'(wr_slot) < DEPTH))
      store[wr_slot] <= wr_data;
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
      rd_data <= '0;
    else if (int'(rd_slot) < DEPTH)
      rd_data <= store[rd_slot];
    else
      rd_data <= '0;
  end

  always_comb
  begin
    for (int i = 0; i < DEPTH; i++)
      all_words[i*WIDTH +: WIDTH] = store[i];
  end

endmodule : rav_regmem

// ### rav_top.sv
// alternate regulator setting bank with an Avalon-MM slave port
// assumes a single 40 MHz clock mclk and a synchronous active-high reset
`timescale 1ns/100ps
`include "rav_cfg.svh"
module rav_top
  import rav_pkg::*;
#(
  parameter int N_SETTINGS = 6
)
(
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic [9:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  output rav_buck_ctl_type core1_ctl,
  output rav_buck_ctl_type processor_ctl,
  output rav_buck_ctl_type memory_ctl,
  output rav_buck_ctl_type io_ctl,
  output rav_buck_ctl_type peripheral_ctl,
  output rav_ldo_ctl_type  linear_one_ctl,
  output logic             alt_controls_applied,
  output logic      [10:0] core1_alt_millivolts,
  output logic      [10:0] linear_one_alt_millivolts
);

  // ************************************************************
  // decode helpers
  // ************************************************************
  function automatic logic is_setting(input logic [7:0] idx);
    return (idx >= `RAV_IDX_CORE1) && (idx <= `RAV_IDX_LINEAR_ONE);
  endfunction : is_setting

  function automatic logic [2:0] slot_of(input logic [7:0] idx);
    logic [7:0] d;
    d = idx - `RAV_IDX_CORE1;
    return is_setting(idx) ? d[2:0] : 3'h7;
  endfunction : slot_of

  // reserved bit of the linear regulator word is never stored, so it reads 0
  function automatic logic [7:0] wr_mask_of(input logic [7:0] idx);
    return (idx == `RAV_IDX_LINEAR_ONE) ? `RAV_LDO_WR_MASK : `RAV_BUCK_WR_MASK;
  endfunction : wr_mask_of

  function automatic logic [10:0] core1_mv(input logic [6:0] code);
    return `RAV_CORE1_BASE_MV + 11'(code) * `RAV_CORE1_STEP_MV;
  endfunction : core1_mv

  function automatic logic [10:0] first_linear_regulator_mv(input logic [5:0] code);
    return `RAV_FIRST_LINEAR_REGULATOR_BASE_MV + 11'(code) * `RAV_FIRST_LINEAR_REGULATOR_STEP_MV;
  endfunction : first_linear_regulator_mv

  // ************************************************************
  // state
  // ************************************************************
  rav_bus_state_type     state;
  rav_bus_state_type     next_state;
  rav_bus_req_type       req;
  rav_bus_req_type       next_req;
  logic                  alt_select;
  logic [7:0]            mem_rd_data;
  logic [8*N_SETTINGS-1:0] mem_words;
  logic [7:0]            stored_core1;
  logic [7:0]            stored_first_linear_regulator;

  // ************************************************************
  // bus decode
  // ************************************************************
  wire logic [7:0] bus_index    = avs_address[9:2];
  wire logic       bus_request  = avs_read ^ avs_write;
  wire logic       req_setting  = is_setting(req.index);
  wire logic       req_ctrl     = (req.index == `RAV_IDX_SET_CTRL);
  wire logic       req_status   = (req.index == `RAV_IDX_SET_STATUS);
  wire logic       commit       = (state == RAV_ANSWER);
  wire logic       mem_write    = commit && req.write && req_setting;
  wire logic       ctrl_write   = commit && req.write && req_ctrl && req.strobe_mask[0];
  wire logic [7:0] wr_keep      = ~(req.strobe_mask & wr_mask_of(req.index));
  wire logic [7:0] merged_word  = (req.data & ~wr_keep) | (mem_rd_data & wr_keep);
  wire logic [2:0] rd_slot      = (state == RAV_IDLE) ? slot_of(bus_index) : slot_of(req.index);

  // read word: settings from memory, control and status from local flops
  wire logic [7:0] read_word =
    req_setting ? mem_rd_data :
    req_ctrl    ? {7'h00, alt_select} :
    req_status  ? {7'h00, alt_controls_applied} :
                  8'h00;

  // ************************************************************
  // bus sequencing: take, fetch, answer with waitrequest low
  // ************************************************************
  always_comb
  begin
    next_state = state;
    next_req   = req;
    case (state)
      RAV_IDLE:
      begin
        if (bus_request)
        begin
          next_req.write       = avs_write;
          next_req.index       = bus_index;
          next_req.data        = avs_writedata[7:0];
          next_req.strobe_mask = {8{avs_byteenable[0]}};
          next_state           = RAV_FETCH;
        end
      end
      RAV_FETCH:
        next_state = RAV_ANSWER;
      RAV_ANSWER:
        next_state = RAV_IDLE;
      default:
        next_state = RAV_IDLE;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      state <= RAV_IDLE;
      req   <= '0;
    end
    else
    begin
      state <= next_state;
      req   <= next_req;
    end
  end

  // waitrequest drops for exactly the answer cycle
  always_ff @(posedge mclk)
  begin
    if (reset)
      avs_waitrequest <= 1'b1;
    else
      avs_waitrequest <= (next_state != RAV_ANSWER);
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
      avs_readdata <= 32'h0000_0000;
    else if (state == RAV_FETCH && !req.write)
      avs_readdata <= {24'h00_0000, read_word};
  end

  // ************************************************************
  // set selection control
  // ************************************************************
  always_ff @(posedge mclk)
  begin
    if (reset)
      alt_select <= 1'b0;
    else if (ctrl_write)
      alt_select <= req.data[`RAV_ALT_SELECT_BIT];
  end

  // ************************************************************
  // storage; a write merges unstrobed and reserved bits from the old word
  // ************************************************************
  rav_regmem
  #(
    .DEPTH      (N_SETTINGS),
    .WIDTH      (8),
    .RESET_WORD (`RAV_SETTING_RESET)
  )
  u_mem
  (
    .mclk      (mclk),
    .reset     (reset),
    .wr_en     (mem_write),
    .wr_slot   (slot_of(req.index)),
    .wr_data   (merged_word),
    .rd_slot   (rd_slot),
    .rd_data   (mem_rd_data),
    .all_words (mem_words)
  );

  // ************************************************************
  // forwarding to the regulators
  // ************************************************************
  rav_fwd u_fwd
  (
    .mclk           (mclk),
    .reset          (reset),
    .alt_selected   (alt_select),
    .words          (mem_words),
    .core1_ctl      (core1_ctl),
    .processor_ctl  (processor_ctl),
    .memory_ctl     (memory_ctl),
    .io_ctl         (io_ctl),
    .peripheral_ctl (peripheral_ctl),
    .linear_one_ctl (linear_one_ctl),
    .applied        (alt_controls_applied)
  );

  // ************************************************************
  // voltage readout of the forwarded setting, 0 while not applied
  // ************************************************************
  assign stored_core1 = mem_words[7:0];
  assign stored_first_linear_regulator  = mem_words[47:40];

  always_ff @(posedge mclk)
  begin
    if (reset || !alt_select)
    begin
      core1_alt_millivolts      <= 11'h000;
      linear_one_alt_millivolts <= 11'h000;
    end
    else
    begin
      core1_alt_millivolts      <= core1_mv(stored_core1[`RAV_BUCK_CODE_MSB:0]);
      linear_one_alt_millivolts <= first_linear_regulator_mv(stored_first_linear_regulator[`RAV_LDO_CODE_MSB:0]);
    end
  end

endmodule : rav_top

// ### rav_top_asserts.sv
// port-level assertions for the alternate regulator setting bank
// assumes it is bound into rav_top and sees only that module's ports
`timescale 1ns/100ps
module rav_top_asserts
  import rav_pkg::*;
(
  input wire logic        mclk,
  input wire logic        reset,
  input wire logic [9:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input rav_buck_ctl_type core1_ctl,
  input rav_buck_ctl_type processor_ctl,
  input rav_buck_ctl_type memory_ctl,
  input rav_buck_ctl_type io_ctl,
  input rav_buck_ctl_type peripheral_ctl,
  input rav_ldo_ctl_type  linear_one_ctl,
  input wire logic        alt_controls_applied,
  input wire logic [10:0] core1_alt_millivolts,
  input wire logic [10:0] linear_one_alt_millivolts
);
  // ********
  // properties
  // ********
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  // a write shows on the outputs two edges after its answer, only while forwarded
  wire done_wr = !avs_waitrequest && avs_write && avs_byteenable[0] && alt_controls_applied;
  property wr_p(logic [7:0] idx, logic [7:0] got);
    done_wr && avs_address[9:2] == idx |-> ##2 got == $past(avs_writedata[7:0], 2);
  endproperty
  answer_gap_a: assert property ($fell(avs_waitrequest) |->
    $past(avs_read || avs_write, 2) ##1 avs_waitrequest) else $error("bad answer timing");
  core_wr_a: assert property (wr_p(8'hb5, core1_ctl)) else $error("core1 ctl");
  proc_wr_a: assert property (wr_p(8'hb6, processor_ctl)) else $error("processor ctl");
  mem_wr_a: assert property (wr_p(8'hb7, memory_ctl)) else $error("memory ctl");
  io_wr_a: assert property (wr_p(8'hb8, io_ctl)) else $error("io ctl");
  peri_wr_a: assert property (wr_p(8'hb9, peripheral_ctl)) else $error("peripheral ctl");
  ldo_wr_a: assert property (done_wr && avs_address[9:2] == 8'hba |-> ##2
    linear_one_ctl == {$past(avs_writedata[7], 2), $past(avs_writedata[5:0], 2)})
    else $error("linear ctl");
  ldo_reserved_a: assert property (!avs_waitrequest && avs_read &&
    avs_address[9:2] == 8'hba |-> !avs_readdata[6]) else $error("reserved bit read 1");
  unsel_zero_a: assert property (!alt_controls_applied |->
    {core1_ctl, processor_ctl, memory_ctl, io_ctl, peripheral_ctl, linear_one_ctl,
     core1_alt_millivolts, linear_one_alt_millivolts} == '0) else $error("not zero");
  core_mv_a: assert property (alt_controls_applied |->
    core1_alt_millivolts == 11'd300 + 11'd10 * core1_ctl.code) else $error("core1 mv");
  ldo_mv_a: assert property (alt_controls_applied |->
    linear_one_alt_millivolts == 11'd600 + 11'd20 * linear_one_ctl.code)
    else $error("linear mv");
  ctl_hold_a: assert property (alt_controls_applied && $past(alt_controls_applied) &&
    $past(avs_waitrequest, 2) |-> $stable(core1_ctl) && $stable(linear_one_ctl))
    else $error("ctl changed without write");
  cover property (done_wr);
  cover property ($rose(alt_controls_applied));
  cover property (!avs_waitrequest && avs_read && avs_address[9:2] == 8'hba);
endmodule : rav_top_asserts

bind rav_top rav_top_asserts chk_i (.mclk(mclk), .reset(reset), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .core1_ctl(core1_ctl), .processor_ctl(processor_ctl),
  .memory_ctl(memory_ctl), .io_ctl(io_ctl), .peripheral_ctl(peripheral_ctl),
  .linear_one_ctl(linear_one_ctl), .alt_controls_applied(alt_controls_applied),
  .core1_alt_millivolts(core1_alt_millivolts),
  .linear_one_alt_millivolts(linear_one_alt_millivolts));

// ### rav_top_test.sv
// self-checking bench for the alternate regulator setting bank
// assumes rav_pkg and rav_top compiled first; drives the Avalon-MM port itself
`timescale 1ns/100ps
module rav_top_test
  import rav_pkg::*;
;
  logic             mclk = 1'b0;
  logic             reset = 1'b1;
  logic [9:0]       avs_address = 10'h000;
  logic             avs_read = 1'b0;
  logic             avs_write = 1'b0;
  logic [31:0]      avs_writedata = 32'h0;
  logic [3:0]       avs_byteenable = 4'h0;
  logic [31:0]      avs_readdata;
  logic             avs_waitrequest;
  rav_buck_ctl_type c0, c1, c2, c3, c4;
  rav_ldo_ctl_type  c5;
  logic             applied;
  logic [10:0]      mv_core, mv_ldo;
  int               errors = 0;
  int               total_checks = 0;
  logic [7:0]       rd;
  logic [7:0]       vals [6] = '{8'hf8, 8'h81, 8'h02, 8'h93, 8'h7f, 8'hff};
  always #12.5 mclk = ~mclk;
  rav_top uut (.mclk(mclk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .core1_ctl(c0),
    .processor_ctl(c1), .memory_ctl(c2), .io_ctl(c3), .peripheral_ctl(c4),
    .linear_one_ctl(c5), .alt_controls_applied(applied), .core1_alt_millivolts(mv_core),
    .linear_one_alt_millivolts(mv_ldo));
  // ********
  // shared tasks
  // ********
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // low address bits and upper data lanes are set to junk: both must be ignored
  task bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd, input logic be);
    int n;
    @(posedge mclk);
    avs_write <= wr;
    avs_read <= ~wr;
    avs_address <= {idx, 2'b11};
    avs_writedata <= {24'hffffff, wd};
    avs_byteenable <= {3'b111, be};
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 20);
    chk(avs_waitrequest, 1'b0);
    rd = avs_readdata[7:0];
    if (!wr) chk(avs_readdata[31:8], 24'h000000);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  task rdchk(input logic [7:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00, 1'b1);
    chk(rd, exp);
  endtask : rdchk
  // outputs follow one edge after the storing edge
  task wr_settle(input logic [7:0] idx, input logic [7:0] wd);
    bus(1'b1, idx, wd, 1'b1);
    @(posedge mclk);
    #1;
  endtask : wr_settle
  function automatic logic [7:0] ctl_of(input int i);
    case (i)
      0: return c0;
      1: return c1;
      2: return c2;
      3: return c3;
      4: return c4;
      default: return {c5.sleep, 1'b0, c5.code};
    endcase
  endfunction : ctl_of
  // ********
  // scenarios
  // ********
  task t_store;
    for (int i = 0; i < 6; i++) rdchk(8'(8'hb5 + i), 8'h00);
    for (int i = 0; i < 6; i++) wr_settle(8'(8'hb5 + i), vals[i]);
    for (int i = 0; i < 6; i++) chk(ctl_of(i), 8'h00);
    chk({applied, mv_core, mv_ldo}, 0);
    for (int i = 0; i < 6; i++) rdchk(8'(8'hb5 + i), vals[i] & (i == 5 ? 8'hbf : 8'hff));
  endtask : t_store
  task t_select;
    wr_settle(8'hf0, 8'h01);
    chk(applied, 1'b1);
    for (int i = 0; i < 6; i++) chk(ctl_of(i), vals[i] & (i == 5 ? 8'hbf : 8'hff));
    chk(mv_core, 11'd1500);
    chk(mv_ldo, 11'd1860);
    rdchk(8'hf1, 8'h01);
    rdchk(8'hf0, 8'h01);
  endtask : t_select
  task t_sleep_walk;
    for (int i = 0; i < 6; i++)
    begin
      wr_settle(8'(8'hb5 + i), 8'h05);
      chk(ctl_of(i), 8'h05);
      wr_settle(8'(8'hb5 + i), 8'h85);
      chk(ctl_of(i), 8'h85);
    end
    wr_settle(8'hb5, 8'h00);
    chk(mv_core, 11'd300);
    wr_settle(8'hba, 8'h40);
    chk({c5, mv_ldo}, {7'h00, 11'd600});
  endtask : t_sleep_walk
  task t_refused;
    bus(1'b1, 8'hb6, 8'h33, 1'b0);
    rdchk(8'hb6, 8'h85);
    bus(1'b1, 8'h10, 8'hff, 1'b1);
    rdchk(8'h10, 8'h00);
    wr_settle(8'hf0, 8'h00);
    for (int i = 0; i < 6; i++) chk(ctl_of(i), 8'h00);
    chk({applied, mv_core}, 0);
    wr_settle(8'hf0, 8'h01);
    chk(ctl_of(1), 8'h85);
  endtask : t_refused
  // a reset in mid-run must clear stored words, selection and outputs
  task t_reset;
    @(posedge mclk);
    reset <= 1'b1;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    #1;
    chk({applied, c1, mv_core}, 0);
    rdchk(8'hb6, 8'h00);
    rdchk(8'hf0, 8'h00);
  endtask : t_reset
  task test_done;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : test_done
  initial
  begin
    #50000;
    errors++;
    test_done();
  end
  initial
  begin
    repeat (8) @(posedge mclk);
    reset <= 1'b0;
    t_store();
    t_select();
    t_sleep_walk();
    t_refused();
    t_reset();
    test_done();
  end
endmodule : rav_top_test
